// [verilog/isr_map.vh]
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
// ==================================================
// Register byte offsets
`define ISR_OFS_FSEL 8'h00
`define ISR_OFS_CTRL 8'h20
`define ISR_OFS_STAT 8'h24
`define ISR_OFS_UDREF 8'h28
`define ISR_OFS_OUTF 8'h2C
`define ISR_OFS_PRESET 8'h40
`define ISR_OFS_JOG 8'h60
`define ISR_OFS_ACC1 8'h64
`define ISR_OFS_ACC2 8'h68
`define ISR_OFS_UPPER 8'h6C
`define ISR_OFS_LOWER 8'h70
// ==================================================
// Control register fields
`define ISR_CTL_PERMIT 0
`define ISR_CTL_HOLDEN 1
`define ISR_CTL_LSEL_LO 2
`define ISR_CTL_LSEL_HI 3
`define ISR_CTL_ATGT 4
`define ISR_CTL_SRC1_LO 5
`define ISR_CTL_SRC1_HI 7
`define ISR_CTL_SRC2_LO 8
`define ISR_CTL_SRC2_HI 10
`define ISR_CTL_RESET 11'h000
// ==================================================
// Input function codes
`define ISR_FN_MAX 8'h9F
`define ISR_FN_EXT2 8'h02
`define ISR_FN_MS1 8'h03
`define ISR_FN_MS2 8'h04
`define ISR_FN_MS3 8'h05
`define ISR_FN_JOG 8'h06
`define ISR_FN_ACC 8'h07
`define ISR_FN_BBNO 8'h08
`define ISR_FN_BBNC 8'h09
`define ISR_FN_HOLD 8'h0A
`define ISR_FN_OH 8'h0B
`define ISR_FN_AEN 8'h0C
`define ISR_FN_THRU 8'h0F
`define ISR_FN_UP 8'h10
`define ISR_FN_DN 8'h11
`define ISR_FSEL_RESET 8'h0F
// ==================================================
// Reference source codes and limit selections
`define ISR_SRC_PANEL 3'h0
`define ISR_SRC_ANALOG 3'h1
`define ISR_SRC_PULSE 3'h4
`define ISR_LSEL_PARAM 2'h0
`define ISR_LSEL_ANALOG 2'h1
// ==================================================
// Timing
`define ISR_CLK_MHZ 10
`define ISR_TICK_US 1000
`define ISR_BLINK_MS 250
`endif

// [verilog/isr_sync.v]
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// Two-stage synchroniser for pin levels
module isr_sync #(
    parameter W = 8
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Data
    input wire [W-1:0] d_in,
    output reg [W-1:0] d_out
);
    reg [W-1:0] meta_r; // First stage, read only by d_out

    // Plain double flop, no enable so pins settle even when frozen
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            d_out <= {W{1'b0}};
        end else begin
            meta_r <= d_in;
            d_out <= meta_r;
        end
    end
endmodule // isr_sync
`default_nettype wire

// [verilog/isr_ramp.v]
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// Output frequency ramp generator
module isr_ramp (
    // Clock, reset, enable
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // Control
    input wire tick,
    input wire run,
    input wire hold,
    input wire load,
    input wire [15:0] load_val,
    input wire [15:0] target,
    input wire [15:0] step,
    // Result
    output reg [15:0] out_r
);
    wire [16:0] up_sum = {1'b0, out_r} + {1'b0, step}; // Headroom
    wire [16:0] dn_lim = {1'b0, target} + {1'b0, step};

    // One step per tick toward the target, never overshooting
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 16'h0000;
        end else if (ce) begin
            if (load) begin
                out_r <= load_val;
            end else if (!run) begin
                // Coasting or stopped: nothing on the output
                out_r <= 16'h0000;
            end else if (tick && !hold) begin
                if (out_r < target) begin
                    out_r <= (up_sum > {1'b0, target}) ? target : up_sum[15:0];
                end else if ({1'b0, out_r} > dn_lim) begin
                    out_r <= out_r - step;
                end else begin
                    out_r <= target;
                end
            end
        end
    end
endmodule // isr_ramp
`default_nettype wire

// [verilog/isr_top.v]
`timescale 1ns/1ns
`default_nettype none
`include "isr_map.vh"
// ==================================================
// Input function decoder and speed reference
// Operation
// (RULE_01) Each terminal has code 0 to 9F
// (RULE_02) Code 2 chooses source set 1/2
// (RULE_03) No set change in run unless permitted
// (RULE_04) Codes 3-5 select eight presets
// (RULE_05) Code 6 selects jog frequency
// (RULE_06) Code 7 selects ramp time set
// (RULE_07) Codes 8/9 inhibit output, indication flashes
// (RULE_08) Inhibit end with run starts search
// (RULE_09) Code A freezes ramp while closed
// (RULE_10) Hold enabled stores frequency, reused at restart; code stores zero while stopped with hold closed
// (RULE_11) Code B raises overheat alarm only
// (RULE_12) Code C gates analog inputs
// (RULE_13) Code F only readable status
// (RULE_14) Up raises, down lowers, else hold
// (RULE_15) Up/down overrides panel, analog, pulse
// (RULE_16) Flag bad up/down assignment
// (RULE_17) Up/down acts only in set 1
// (RULE_18) No hold: clear on stop, power
// (RULE_19) Hold: keep, clear by key without run
// (RULE_20) Upper bound; parameter floor reached on run
// (RULE_21) Analog floor needs run plus key
// (RULE_22) Both floors: key lifts to analog
// (RULE_23) Up/down moves at selected ramp rate
module isr_top #(
    parameter N_IN = 7,
    parameter [23:0] TICK_CYC = `ISR_TICK_US * `ISR_CLK_MHZ,
    parameter [15:0] BLINK_TICKS = (`ISR_BLINK_MS * 1000) / `ISR_TICK_US
) (
    // Clock, reset, enable
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Pins
    input wire [N_IN-1:0] term_in,
    input wire run_in,
    // Same-clock reference sources
    input wire [15:0] analog_input_one,
    input wire [15:0] analog_input_two,
    input wire [15:0] pulse_ref_i,
    // Results
    output reg [15:0] freq_ref_o,
    output wire [15:0] out_freq_o,
    output reg accel_set2_o,
    output reg source_set2_o,
    output reg output_inhibit_o,
    output reg output_inhibit_indication,
    output reg speed_search_o,
    output reg overheat_alarm,
    output reg analog_one_en_o,
    output reg analog_two_en_o,
    output reg config_conflict_error
);
    // ==================================================
    // Reset release and pin synchronisers
    reg [1:0] rst_sh_r; // Reset release chain
    wire rst_s_n = rst_sh_r[1];
    wire [N_IN:0] pins_s; // Synchronised pins
    wire [N_IN-1:0] din_s = pins_s[N_IN-1:0];
    wire run_s = pins_s[N_IN];

    // Asynchronous assert, synchronous release
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sh_r <= 2'b00;
        end else begin
            rst_sh_r <= {rst_sh_r[0], 1'b1};
        end
    end

    isr_sync #(.W(N_IN + 1)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_s_n),
        .d_in({run_in, term_in}),
        .d_out(pins_s)
    );

    // ==================================================
    // Software-visible settings
    reg [7:0] input_function_select [0:N_IN-1]; // Per terminal
    reg [15:0] preset_r [0:7]; // Stored speed references
    reg [10:0] ctrl_r; // Mode bits
    reg [15:0] jog_frequency_value;
    reg [15:0] acc1_r; // Step per tick, set 1
    reg [15:0] acc2_r; // Step per tick, set 2
    reg [15:0] reference_upper_limit;
    reg [15:0] reference_lower_limit;
    wire run_switch_permit = ctrl_r[`ISR_CTL_PERMIT];
    wire reference_hold_enable = ctrl_r[`ISR_CTL_HOLDEN];
    wire [1:0] updown_lower_limit_select = ctrl_r[`ISR_CTL_LSEL_HI:`ISR_CTL_LSEL_LO];
    wire analog_disable_target = ctrl_r[`ISR_CTL_ATGT];
    wire [2:0] reference_source_set1 = ctrl_r[`ISR_CTL_SRC1_HI:`ISR_CTL_SRC1_LO];
    wire [2:0] reference_source_set2 = ctrl_r[`ISR_CTL_SRC2_HI:`ISR_CTL_SRC2_LO];

    // Byte-lane mask from the select lines
    function [31:0] lane_mask;
        input [3:0] s;
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    wire [31:0] wm = lane_mask(wb_sel_i);
    wire [5:0] widx = wb_adr_i[7:2]; // Word index
    wire wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    wire [31:0] wdm = wb_dat_i & wm;
    integer i;

    // Register writes take effect on the cycle the answer is raised
    always @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
            for (i = 0; i < N_IN; i = i + 1) begin
                input_function_select[i] <= `ISR_FSEL_RESET;
            end
            for (i = 0; i < 8; i = i + 1) begin
                preset_r[i] <= 16'h0000;
            end
            ctrl_r <= `ISR_CTL_RESET;
            jog_frequency_value <= 16'h0000;
            acc1_r <= 16'h0001;
            acc2_r <= 16'h0001;
            reference_upper_limit <= 16'hFFFF;
            reference_lower_limit <= 16'h0000;
        end else if (ce && wr_go) begin
            for (i = 0; i < N_IN; i = i + 1) begin
                // Out-of-range codes leave the old function in place
                if (widx == (`ISR_OFS_FSEL >> 2) + i && wm[0] && wb_dat_i[7:0] <= `ISR_FN_MAX) begin // RULE_01
                    input_function_select[i] <= wb_dat_i[7:0];
                end
            end
            for (i = 0; i < 8; i = i + 1) begin
                if (widx == (`ISR_OFS_PRESET >> 2) + i) begin
                    preset_r[i] <= (preset_r[i] & ~wm[15:0]) | wdm[15:0];
                end
            end
            case (widx)
                `ISR_OFS_CTRL >> 2: ctrl_r <= (ctrl_r & ~wm[10:0]) | wdm[10:0];
                `ISR_OFS_JOG >> 2: jog_frequency_value <= (jog_frequency_value & ~wm[15:0]) | wdm[15:0];
                `ISR_OFS_ACC1 >> 2: acc1_r <= (acc1_r & ~wm[15:0]) | wdm[15:0];
                `ISR_OFS_ACC2 >> 2: acc2_r <= (acc2_r & ~wm[15:0]) | wdm[15:0];
                `ISR_OFS_UPPER >> 2: reference_upper_limit <= (reference_upper_limit & ~wm[15:0]) | wdm[15:0];
                `ISR_OFS_LOWER >> 2: reference_lower_limit <= (reference_lower_limit & ~wm[15:0]) | wdm[15:0];
                default: ;
            endcase
        end
    end

    // ==================================================
    // Per-terminal function decode
    wire [N_IN-1:0] a_ext2, a_ms1, a_ms2, a_ms3, a_jog, a_acc, a_bbno, a_bbnc;
    wire [N_IN-1:0] a_hold, a_oh, a_aen, a_thru, a_up, a_dn;

    genvar g;
    generate
        for (g = 0; g < N_IN; g = g + 1) begin : g_dec
            wire [7:0] c = input_function_select[g];
            assign a_ext2[g] = (c == `ISR_FN_EXT2);
            assign a_ms1[g] = (c == `ISR_FN_MS1);
            assign a_ms2[g] = (c == `ISR_FN_MS2);
            assign a_ms3[g] = (c == `ISR_FN_MS3);
            assign a_jog[g] = (c == `ISR_FN_JOG);
            assign a_acc[g] = (c == `ISR_FN_ACC);
            assign a_bbno[g] = (c == `ISR_FN_BBNO);
            assign a_bbnc[g] = (c == `ISR_FN_BBNC);
            assign a_hold[g] = (c == `ISR_FN_HOLD);
            assign a_oh[g] = (c == `ISR_FN_OH);
            assign a_aen[g] = (c == `ISR_FN_AEN);
            assign a_thru[g] = (c == `ISR_FN_THRU);
            assign a_up[g] = (c == `ISR_FN_UP);
            assign a_dn[g] = (c == `ISR_FN_DN);
        end
    endgenerate

    // Active contacts per function; code 9 counts when open
    wire ext2_cl = |(a_ext2 & din_s);
    wire [2:0] ms_idx = {|(a_ms3 & din_s), |(a_ms2 & din_s), |(a_ms1 & din_s)}; // RULE_04
    wire jog_cl = |(a_jog & din_s);
    wire acc2_cl = |(a_acc & din_s); // RULE_06
    wire bb_now = |(a_bbno & din_s) | |(a_bbnc & ~din_s); // RULE_07
    wire hold_cl = |(a_hold & din_s); // RULE_09
    wire up_cl = |(a_up & din_s);
    wire dn_cl = |(a_dn & din_s);
    wire aen_used = |a_aen;
    wire aen_cl = |(a_aen & din_s);
    // Both keys assigned and no clash with ramp hold
    wire ud_bad = (|a_up ^ |a_dn) | ((|a_up | |a_dn) & |a_hold); // RULE_16
    wire ud_cfg = |a_up & |a_dn & ~ud_bad;

    // ==================================================
    // Tick and blink timing
    reg [23:0] tick_cnt_r;
    reg tick_r; // One cycle per tick period
    reg [15:0] blink_cnt_r;
    reg blink_r;

    // Free-running prescaler for ramp and flashing
    always @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
            tick_cnt_r <= 24'h000000;
            tick_r <= 1'b0;
            blink_cnt_r <= 16'h0000;
            blink_r <= 1'b0;
        end else if (ce) begin
            tick_r <= (tick_cnt_r == TICK_CYC - 24'h000001);
            tick_cnt_r <= (tick_cnt_r == TICK_CYC - 24'h000001) ? 24'h000000 : tick_cnt_r + 24'h000001;
            if (tick_r) begin
                if (blink_cnt_r == BLINK_TICKS - 16'h0001) begin
                    blink_cnt_r <= 16'h0000;
                    blink_r <= ~blink_r;
                end else begin
                    blink_cnt_r <= blink_cnt_r + 16'h0001;
                end
            end
        end
    end

    // ==================================================
    // Sequencing flags
    reg run_d_r; // Run seen last cycle
    reg [15:0] saved_freq_r; // Frequency kept under ramp hold
    reg [15:0] ud_ref_r; // Up/down reference
    wire [15:0] out_freq;
    wire run_rise = run_s & ~run_d_r;
    wire [15:0] step = acc2_cl ? acc2_r : acc1_r; // RULE_23

    // Set selection, inhibit, alarms and analog gating
    always @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
            run_d_r <= 1'b0;
            source_set2_o <= 1'b0;
            output_inhibit_o <= 1'b0;
            output_inhibit_indication <= 1'b0;
            speed_search_o <= 1'b0;
            overheat_alarm <= 1'b0;
            analog_one_en_o <= 1'b1;
            analog_two_en_o <= 1'b1;
            config_conflict_error <= 1'b0;
            accel_set2_o <= 1'b0;
            saved_freq_r <= 16'h0000;
        end else if (ce) begin
            run_d_r <= run_s;
            // Switching sets mid-run would jump the reference
            if (!run_s || run_switch_permit) begin // RULE_03
                source_set2_o <= ext2_cl; // RULE_02
            end
            output_inhibit_o <= bb_now; // RULE_07
            output_inhibit_indication <= bb_now & blink_r; // RULE_07
            speed_search_o <= output_inhibit_o & ~bb_now & run_s; // RULE_08
            overheat_alarm <= |(a_oh & din_s); // RULE_11
            // Closed contact disregards only the chosen input, open disregards both
            if (aen_used) begin // RULE_12
                analog_one_en_o <= aen_cl & analog_disable_target;
                analog_two_en_o <= aen_cl & ~analog_disable_target;
            end else begin
                analog_one_en_o <= 1'b1;
                analog_two_en_o <= 1'b1;
            end
            config_conflict_error <= ud_bad; // RULE_16
            accel_set2_o <= acc2_cl; // RULE_06
            if (reference_hold_enable && hold_cl) begin
                saved_freq_r <= out_freq; // RULE_10
            end
        end
    end

    // ==================================================
    // Up/down reference
    wire pfloor_on = (updown_lower_limit_select != `ISR_LSEL_ANALOG);
    wire afloor_on = (updown_lower_limit_select != `ISR_LSEL_PARAM);
    wire [15:0] afloor = analog_input_one; // Analog lower limit
    wire [15:0] floor_v = pfloor_on ? reference_lower_limit : 16'h0000;
    wire [16:0] ud_sum = {1'b0, ud_ref_r} + {1'b0, step};
    wire [16:0] ud_flr = {1'b0, floor_v} + {1'b0, step};
    wire ud_key = up_cl | dn_cl;

    // Keys act per tick so the rate follows the ramp time set
    always @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ud_ref_r <= 16'h0000;
        end else if (ce) begin
            if (!reference_hold_enable && !run_s) begin
                ud_ref_r <= 16'h0000; // RULE_18
            end else if (reference_hold_enable && ud_key && !run_s) begin
                ud_ref_r <= 16'h0000; // RULE_19
            end else if (run_s && tick_r) begin
                if (pfloor_on && ud_ref_r < reference_lower_limit) begin
                    ud_ref_r <= reference_lower_limit; // RULE_20
                end else if (afloor_on && ud_key && ud_ref_r < afloor) begin
                    // Analog floor is approached only with a key held
                    ud_ref_r <= (ud_sum > {1'b0, afloor}) ? afloor : ud_sum[15:0]; // RULE_21 RULE_22
                end else if (up_cl && !dn_cl) begin
                    ud_ref_r <= (ud_sum > {1'b0, reference_upper_limit}) ? reference_upper_limit
                        : ud_sum[15:0]; // RULE_14 RULE_20
                end else if (dn_cl && !up_cl) begin
                    ud_ref_r <= ({1'b0, ud_ref_r} < ud_flr) ? floor_v : ud_ref_r - step; // RULE_14
                end
            end
        end
    end

    // ==================================================
    // Reference selection
    reg [15:0] ref_nxt;
    reg [15:0] src_ref;
    reg [2:0] src_code;

    // Jog beats presets, presets beat the set source
    always @* begin
        src_code = source_set2_o ? reference_source_set2 : reference_source_set1;
        case (src_code)
            `ISR_SRC_ANALOG: src_ref = analog_one_en_o ? analog_input_one
                : (analog_two_en_o ? analog_input_two : 16'h0000);
            `ISR_SRC_PULSE: src_ref = pulse_ref_i;
            default: src_ref = preset_r[0];
        endcase
        // Keys take over the usual sources in set 1 only
        if (ud_cfg && !source_set2_o && (src_code == `ISR_SRC_PANEL || src_code == `ISR_SRC_ANALOG
            || src_code == `ISR_SRC_PULSE)) begin // RULE_15 RULE_17
            src_ref = ud_ref_r;
        end
        if (jog_cl) begin
            ref_nxt = jog_frequency_value; // RULE_05
        end else if (ms_idx != 3'h0) begin
            ref_nxt = preset_r[ms_idx]; // RULE_04
        end else begin
            ref_nxt = src_ref;
        end
    end

    // Registered reference for the ramp
    always @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
            freq_ref_o <= 16'h0000;
        end else if (ce) begin
            freq_ref_o <= ref_nxt;
        end
    end

    // ==================================================
    // Ramp generator; held speed reloads only if hold stays open while stopped and closes with run
    isr_ramp u_ramp (
        .clk_sys(clk_sys),
        .rst_n(rst_s_n),
        .ce(ce),
        .tick(tick_r),
        .run(run_s & ~output_inhibit_o),
        .hold(hold_cl), // RULE_09
        .load(run_rise & reference_hold_enable & hold_cl), // RULE_10
        .load_val(saved_freq_r),
        .target(freq_ref_o),
        .step(step),
        .out_r(out_freq)
    );
    assign out_freq_o = out_freq;

    // ==================================================
    // Bus answer and read data
    reg [31:0] rd_nxt;
    reg [31:0] stat_w;
    integer j;

    // Status word; through-mode inputs shown apart
    always @* begin
        stat_w = 32'h00000000;
        stat_w[N_IN-1:0] = din_s;
        stat_w[N_IN+7:8] = din_s & a_thru; // RULE_13
        stat_w[16] = output_inhibit_o;
        stat_w[17] = overheat_alarm;
        stat_w[18] = config_conflict_error;
        stat_w[19] = source_set2_o;
        stat_w[20] = hold_cl;
        stat_w[21] = run_s;
        stat_w[22] = accel_set2_o;
        rd_nxt = 32'h00000000;
        for (j = 0; j < N_IN; j = j + 1) begin
            if (widx == (`ISR_OFS_FSEL >> 2) + j) begin
                rd_nxt = {24'h000000, input_function_select[j]};
            end
        end
        for (j = 0; j < 8; j = j + 1) begin
            if (widx == (`ISR_OFS_PRESET >> 2) + j) begin
                rd_nxt = {16'h0000, preset_r[j]};
            end
        end
        case (widx)
            `ISR_OFS_CTRL >> 2: rd_nxt = {21'h000000, ctrl_r};
            `ISR_OFS_STAT >> 2: rd_nxt = stat_w;
            `ISR_OFS_UDREF >> 2: rd_nxt = {16'h0000, ud_ref_r};
            `ISR_OFS_OUTF >> 2: rd_nxt = {16'h0000, out_freq};
            `ISR_OFS_JOG >> 2: rd_nxt = {16'h0000, jog_frequency_value};
            `ISR_OFS_ACC1 >> 2: rd_nxt = {16'h0000, acc1_r};
            `ISR_OFS_ACC2 >> 2: rd_nxt = {16'h0000, acc2_r};
            `ISR_OFS_UPPER >> 2: rd_nxt = {16'h0000, reference_upper_limit};
            `ISR_OFS_LOWER >> 2: rd_nxt = {16'h0000, reference_lower_limit};
            default: ;
        endcase
    end

    // Every access is answered one cycle later, unmapped reads zero
    always @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= rd_nxt;
        end
    end
endmodule // isr_top
`default_nettype wire

// [sim/isr_top_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checks
module isr_top_assertions (
    // Clock, reset, enable
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // Bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Results
    input wire [15:0] out_freq_o,
    input wire output_inhibit_o,
    input wire output_inhibit_indication,
    input wire speed_search_o
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Request not yet answered
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    endsequence
    chk_ack_answers: assert property (s_req |=> wb_ack_o) else $error("no ack");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    chk_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'hFC)
        |-> wb_dat_o == 32'h0) else $error("unmapped data");
    // Indication is registered in the same cycle as the inhibit level, never after it
    chk_flash_gated: assert property (output_inhibit_indication
        |-> output_inhibit_o || $past(output_inhibit_o)) else $error("flash idle");
    chk_coast_zero: assert property (output_inhibit_o [*3] |-> out_freq_o == 16'h0000) else $error("no coast");
    chk_search_pulse: assert property (speed_search_o |=> !speed_search_o) else $error("long search");
    chk_search_cause: assert property (speed_search_o
        |-> $past(output_inhibit_o) || $past(output_inhibit_o, 2)) else $error("stray search");
endmodule // isr_top_assertions
bind isr_top isr_top_assertions chk (.clk_sys, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .out_freq_o, .output_inhibit_o, .output_inhibit_indication, .speed_search_o);
`default_nettype wire

// [sim/isr_switches.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Contacts and run switch at the terminals
module isr_switches (
    // Clock
    input wire clk_sys,
    // Contacts, 1 = closed
    output logic [6:0] term_in,
    output logic run_in
);
    initial term_in = 7'h00;
    initial run_in = 1'b0;
    // Moves just after an edge, then stays put like a real switch
    task pin(input int i, input logic v);
        @(posedge clk_sys);
        term_in[i] <= v;
    endtask
    task run(input logic v);
        @(posedge clk_sys);
        run_in <= v;
    endtask
endmodule // isr_switches
`default_nettype wire

// [sim/input_function_speed_reference_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
// ==========
// Bench
module input_function_speed_reference_test;
    logic clk_sys = 0;
    logic rst_n = 0;
    logic cyc = 0;
    logic we = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    wire [31:0] dat_o;
    wire ack, run, acc2, set2, inh, ind, srch, oh, en1, en2, cfl;
    wire [6:0] term;
    wire [15:0] fref, fout;
    logic ce = 1'b1;
    logic [15:0] an1 = 16'h1234, an2 = 16'h2345, pls = 16'h3456;
    int n_fail = 0, tests_run = 0, cyc_n = 0, k, hi;
    always #50 clk_sys = ~clk_sys;
    isr_switches sw (.clk_sys(clk_sys), .term_in(term), .run_in(run));
    // Short tick and blink so flashing shows in a few dozen cycles
    isr_top #(.TICK_CYC(24'h4), .BLINK_TICKS(16'h2)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .term_in(term), .run_in(run), .analog_input_one(an1),
        .analog_input_two(an2), .pulse_ref_i(pls), .freq_ref_o(fref), .out_freq_o(fout),
        .accel_set2_o(acc2), .source_set2_o(set2), .output_inhibit_o(inh), .output_inhibit_indication(ind),
        .speed_search_o(srch), .overheat_alarm(oh), .analog_one_en_o(en1), .analog_two_en_o(en2),
        .config_conflict_error(cfl));
    // One classic cycle; holds until ack is seen at an edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
    endtask
    task fs(input int i, input logic [7:0] c);
        wb(1'b1, 8'(4 * i), {24'h0, c});
        repeat (6) @(posedge clk_sys);
    endtask
    // Two sync flops plus output register, with margin
    task pin(input int i, input logic v);
        sw.pin(i, v);
        repeat (6) @(posedge clk_sys);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        wb(1'b0, 8'hFC, 32'h0);
        `CHK("unmapped", 32'h0, rdat)
        fs(0, 8'hA0);
        wb(1'b0, 8'h00, 32'h0);
        `CHK("fsel", 32'h0F, rdat)
        pin(0, 1'b1);
        wb(1'b0, 8'h24, 32'h0);
        `CHK("through", 15'h0101, rdat[14:0])
        for (k = 0; k < 8; k++)
            wb(1'b1, 8'(8'h40 + 4 * k), 32'h100 + k);
        for (k = 0; k < 3; k++)
            fs(k, 8'(3 + k));
        for (k = 0; k < 8; k++) begin
            sw.pin(0, k[0]);
            sw.pin(1, k[1]);
            pin(2, k[2]);
            `CHK("preset", 16'(16'h100 + k), fref)
        end
        wb(1'b1, 8'h60, 32'h777);
        fs(3, 8'h06);
        pin(3, 1'b1);
        `CHK("jog", 16'h777, fref)
        fs(4, 8'h07);
        pin(4, 1'b1);
        `CHK("accel", 1'b1, acc2)
        fs(5, 8'h02);
        pin(5, 1'b1);
        `CHK("set2", 1'b1, set2)
        sw.run(1'b1);
        pin(5, 1'b0);
        `CHK("set2 run", 1'b1, set2)
        sw.run(1'b0);
        pin(5, 1'b0);
        `CHK("set2 stop", 1'b0, set2)
        fs(5, 8'h08);
        sw.run(1'b1);
        pin(5, 1'b1);
        `CHK("inhibit", 1'b1, inh)
        hi = 0;
        repeat (40) @(posedge clk_sys) hi += ind;
        `CHK("flash", 1'b1, hi > 0 && hi < 40)
        sw.pin(5, 1'b0);
        hi = 0;
        repeat (8) @(posedge clk_sys) hi += srch;
        `CHK("search", 1'b1, hi == 1)
        fs(6, 8'h09);
        `CHK("nc inhibit", 1'b1, inh)
        sw.run(1'b0);
        fs(0, 8'h0B);
        `CHK("overheat", 1'b1, oh)
        fs(1, 8'h0C);
        `CHK("an en", 2'b01, {en1, en2})
        pin(1, 1'b0);
        `CHK("an dis", 2'b00, {en1, en2})
        fs(2, 8'h10);
        `CHK("up only", 1'b1, cfl)
        fs(3, 8'h11);
        `CHK("up down", 1'b0, cfl)
        wb(1'b1, 8'h6C, 32'h3);
        sw.pin(3, 1'b0);
        sw.pin(6, 1'b1);
        sw.run(1'b1);
        repeat (60) @(posedge clk_sys);
        `CHK("up", 16'h3, fref)
        `CHK("ramp", 16'h3, fout)
        ce <= 1'b0;
        sw.run(1'b0);
        pin(2, 1'b0);
        `CHK("freeze", 16'h3, fref)
        ce <= 1'b1;
        pin(2, 1'b0);
        `CHK("stop", 16'h0, fref)
        fs(4, 8'h0A);
        `CHK("with hold", 1'b1, cfl)
        wb(1'b1, 8'h20, 32'h80);
        pin(1, 1'b1);
        `CHK("pulse", pls, fref)
        wb(1'b1, 8'h20, 32'h20);
        pin(1, 1'b1);
        `CHK("analog", an2, fref)
        tally_and_finish();
    end
endmodule // input_function_speed_reference_test
`default_nettype wire
